// ---- core/rsmc_top.sv ----
// Strap capture at hard reset release and precharge of three open bus pins.
// Assumes straps are board pins, asynchronous to clk_sys, and that the
// bus logic drives the assert requests synchronously to clk_sys.
//
// How it works
// R01 - Latch mode straps when hard reset releases.
// R02 - Width strap high selects 64-bit, low 32-bit.
// R03 - Retry strap 0 disables, 1 enables retry.
// R04 - System keeps retry input low without retry.
// R05 - Quiesce ack high selects standard precharge.
// R06 - Quiesce ack low selects extended precharge.
// R07 - Write-only strap at release picks PLL handling.
// R08 - System holds write-only low for fractional ratios.
// R09 - Integer ratios allow either write-only level.
// R10 - Precharge busy and retry pins high first.
// R11 - Standard precharge lasts about half cycle.
// R12 - Extended precharge lasts one full cycle.
// R13 - Captured modes hold until next hard reset.
`include "rsmc_defs.svh"

module rsmc_top
   import rsmc_pkg::*;
#(
   parameter int BUS_CLKS = `RSMC_BUS_CLKS,
   parameter int CNT_W    = `RSMC_CNT_W
) (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Reset and strap pins.
   input  wire logic hard_reset_n,
   input  wire logic bus_width_strap,
   input  wire logic data_retry_in,
   input  wire logic quiesce_ack_in,
   input  wire logic write_only_strap,
   // Assert requests from the bus logic.
   input  wire logic addr_bus_busy_req,
   input  wire logic data_bus_busy_req,
   input  wire logic addr_retry_req,
   // Address bus busy pin.
   input  wire logic addr_bus_busy_n_i,
   output logic      addr_bus_busy_n_o,
   output logic      addr_bus_busy_n_oe,
   // Data bus busy pin.
   input  wire logic data_bus_busy_n_i,
   output logic      data_bus_busy_n_o,
   output logic      data_bus_busy_n_oe,
   // Address retry pin.
   input  wire logic addr_retry_n_i,
   output logic      addr_retry_n_o,
   output logic      addr_retry_n_oe,
   // Captured modes and status.
   output logic      cfg_valid_r,
   output logic      bus_64bit_r,
   output logic      data_retry_en_r,
   output logic      ext_precharge_r,
   output logic      pll_div_sel_r,
   output logic      retry_strap_err_r,
   output logic      precharge_busy_r,
   output logic      bus_pins_seen_r
);

   localparam int NPIN = `RSMC_NUM_PINS;
   localparam int NSYN = 5 + NPIN;

   // Precharge lengths in system clocks; a half cycle never drops below one.
   localparam int STD_LEN_I = (BUS_CLKS / 2 < 1) ? 1 : BUS_CLKS / 2;
   localparam int EXT_LEN_I = (BUS_CLKS < 1) ? 1 : BUS_CLKS;
   localparam logic [CNT_W-1:0] STD_LEN = CNT_W'(STD_LEN_I);
   localparam logic [CNT_W-1:0] EXT_LEN = CNT_W'(EXT_LEN_I);

   // Index of each pin input in the synchroniser vector.
   localparam int IX_HRST  = 0;
   localparam int IX_WIDTH = 1;
   localparam int IX_RETRY = 2;
   localparam int IX_QUIESCE_ACK_IN  = 3;
   localparam int IX_WONLY = 4;
   localparam int IX_PIN0  = 5;

   // Bus pins idle high, so their stages start high and no false low shows after reset.
   localparam logic [NSYN-1:0] SYN_RST = NSYN'({NPIN{1'b1}}) << IX_PIN0;

   // A filtered level moves only when the second and third stages agree.
   function automatic logic settle(input logic s2, input logic s3, input logic cur);
      settle = (s2 == s3) ? s3 : cur;
   endfunction : settle

   logic [NSYN-1:0] raw_in;
   logic [NSYN-1:0] sync1_r;
   logic [NSYN-1:0] sync2_r;
   logic [NSYN-1:0] sync3_r;
   logic [NSYN-1:0] lvl_r;
   logic [NSYN-1:0] lvl_nxt;
   logic            hrst_lvl_d_r;
   logic            release_evt;
   logic            assert_evt;
   logic [NPIN-1:0] req_vec;
   logic [NPIN-1:0] pin_o_vec;
   logic [NPIN-1:0] pin_oe_vec;
   logic [NPIN-1:0] pc_act_vec;
   logic [CNT_W-1:0] pc_len;

   // Gather all asynchronous pins so they share one chain and one latency.
   assign raw_in = {addr_retry_n_i, data_bus_busy_n_i, addr_bus_busy_n_i,
                    write_only_strap, quiesce_ack_in, data_retry_in,
                    bus_width_strap, hard_reset_n};

   // Three-stage synchroniser; stage one feeds only stage two.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= SYN_RST;
         sync2_r <= SYN_RST;
         sync3_r <= SYN_RST;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Filter each synchronised input with the agreement test.
   generate
      for (genvar g = 0; g < NSYN; g++) begin : g_filt
         assign lvl_nxt[g] = settle(sync2_r[g], sync3_r[g], lvl_r[g]);
      end
   endgenerate

   // Filtered hard reset starts low, so it reads as asserted until seen high.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lvl_r        <= SYN_RST;
         hrst_lvl_d_r <= 1'b0;
      end else begin
         lvl_r        <= lvl_nxt;
         hrst_lvl_d_r <= lvl_r[IX_HRST];
      end
   end

   // R01 release edge detect.
   assign release_evt = lvl_r[IX_HRST] & ~hrst_lvl_d_r;
   assign assert_evt  = ~lvl_r[IX_HRST] & hrst_lvl_d_r;

   // Capture the straps at release and hold them; straps share the chain
   // with hard reset, so the sampled levels are those at the release edge.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus_64bit_r     <= `RSMC_RST_BUS64;
         data_retry_en_r <= `RSMC_RST_RETRY;
         ext_precharge_r <= `RSMC_RST_EXT_PC;
         pll_div_sel_r   <= `RSMC_RST_PLL_SEL;
      end else if (release_evt) begin
         // R02 width select.
         bus_64bit_r     <= (lvl_r[IX_WIDTH] == `RSMC_BUS64_LVL);
         // R03 retry select.
         data_retry_en_r <= (lvl_r[IX_RETRY] == `RSMC_RETRY_ON_LVL);
         // R05 R06 precharge select.
         ext_precharge_r <= (lvl_r[IX_QUIESCE_ACK_IN] != `RSMC_STD_PC_LVL);
         // R07 PLL handling sample.
         pll_div_sel_r   <= lvl_r[IX_WONLY];
      end
      // R13 hold captured modes; no other branch writes them.
   end

   // Modes are valid from the release until hard reset asserts again.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg_valid_r <= 1'b0;
      end else if (release_evt) begin
         cfg_valid_r <= 1'b1;
      end else if (assert_evt) begin
         cfg_valid_r <= 1'b0;
      end
   end

   // Flag a retry input seen high while retry mode is off. The flag is
   // sticky until the next release, which alone clears it, and a violation
   // in that same cycle cannot occur because the mode is only just chosen.
   // While hard reset is held the pin carries the next strap, so it is not judged.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         retry_strap_err_r <= 1'b0;
      end else if (release_evt) begin
         retry_strap_err_r <= 1'b0;
      end else if (cfg_valid_r && lvl_r[IX_HRST] && !data_retry_en_r && lvl_r[IX_RETRY]) begin
         // R04 retry input kept low.
         retry_strap_err_r <= 1'b1;
      end
   end

   // R11 R12 precharge length by mode.
   assign pc_len = ext_precharge_r ? EXT_LEN : STD_LEN;

   // Requests are ignored until the modes are captured, since the
   // precharge length is not yet known during hard reset.
   assign req_vec = {addr_retry_req, data_bus_busy_req, addr_bus_busy_req} &
                    {NPIN{cfg_valid_r}};

   // One precharge sequencer per open bus pin.
   generate
      for (genvar p = 0; p < NPIN; p++) begin : g_pin
         // R10 per pin precharge.
         rsmc_precharge #(
            .CNT_W     (CNT_W)
         ) u_pc (
            .clk_sys   (clk_sys),
            .nrst      (nrst),
            .drive_low (req_vec[p]),
            .pc_len    (pc_len),
            .pin_o     (pin_o_vec[p]),
            .pin_oe    (pin_oe_vec[p]),
            .pc_active (pc_act_vec[p])
         );
      end
   endgenerate

   assign addr_bus_busy_n_o  = pin_o_vec[0];
   assign addr_bus_busy_n_oe = pin_oe_vec[0];
   assign data_bus_busy_n_o  = pin_o_vec[1];
   assign data_bus_busy_n_oe = pin_oe_vec[1];
   assign addr_retry_n_o     = pin_o_vec[2];
   assign addr_retry_n_oe    = pin_oe_vec[2];

   // Status: any precharge running, and any bus pin seen low on the wire.
   // The wire view lags the pins by the synchroniser and filter delay.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         precharge_busy_r <= 1'b0;
         bus_pins_seen_r  <= 1'b0;
      end else begin
         precharge_busy_r <= |pc_act_vec;
         bus_pins_seen_r  <= ~&lvl_r[IX_PIN0 +: NPIN];
      end
   end

endmodule : rsmc_top

// ---- common/rsmc_defs.svh ----
// Constants for the reset strap mode capture block.
// Assumes inclusion by bare name from the package and the core modules.
`ifndef RSMC_DEFS_SVH
`define RSMC_DEFS_SVH

// Reset values of the captured modes, held until the first release.
`define RSMC_RST_BUS64     1'b1
`define RSMC_RST_RETRY     1'b0
`define RSMC_RST_EXT_PC    1'b0
`define RSMC_RST_PLL_SEL   1'b0

// Strap levels that select each mode.
`define RSMC_BUS64_LVL     1'b1
`define RSMC_RETRY_ON_LVL  1'b1
`define RSMC_STD_PC_LVL    1'b1

// System clocks per bus cycle, and width of the precharge counter.
`define RSMC_BUS_CLKS      4
`define RSMC_CNT_W         4

// Number of bus pins that take a precharge.
`define RSMC_NUM_PINS      3

`endif

// ---- common/rsmc_pkg.sv ----
// Types shared by the reset strap mode capture block.
// Assumes rsmc_defs.svh is on the include path.
`include "rsmc_defs.svh"

package rsmc_pkg;

   // States of one precharged open bus pin.
   typedef enum logic [1:0] {
      RSMC_PIN_FLOAT,
      RSMC_PIN_ASSERT,
      RSMC_PIN_PRECHG
   } rsmc_pin_state_t;

endpackage : rsmc_pkg

// ---- core/rsmc_precharge.sv ----
// One open bus pin: assert low, precharge high, then release.
// Assumes the drive request is synchronous to clk_sys.
`include "rsmc_defs.svh"

module rsmc_precharge
   import rsmc_pkg::*;
#(
   parameter int CNT_W = `RSMC_CNT_W
) (
   // Clock and reset.
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   // Control from the bus logic.
   input  wire logic             drive_low,
   input  wire logic [CNT_W-1:0] pc_len,
   // Pin drive.
   output logic                  pin_o,
   output logic                  pin_oe,
   output logic                  pc_active
);

   rsmc_pin_state_t  state_r;
   logic [CNT_W-1:0] cnt_r;

   // Pin sequence; a new assert request cuts a running precharge short.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= RSMC_PIN_FLOAT;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            RSMC_PIN_FLOAT: begin
               if (drive_low) begin
                  state_r <= RSMC_PIN_ASSERT;
               end
            end
            RSMC_PIN_ASSERT: begin
               // R10 precharge before tristate.
               if (!drive_low) begin
                  state_r <= RSMC_PIN_PRECHG;
                  cnt_r   <= pc_len;
               end
            end
            RSMC_PIN_PRECHG: begin
               if (drive_low) begin
                  state_r <= RSMC_PIN_ASSERT;
               end else if (cnt_r <= CNT_W'(1)) begin
                  state_r <= RSMC_PIN_FLOAT;
               end
               cnt_r <= cnt_r - CNT_W'(1);
            end
            default: begin
               state_r <= RSMC_PIN_FLOAT;
            end
         endcase
      end
   end

   // Registered pin drive, one cycle behind the state for glitch-free edges.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pin_o     <= 1'b1;
         pin_oe    <= 1'b0;
         pc_active <= 1'b0;
      end else begin
         pin_o     <= (state_r != RSMC_PIN_ASSERT);
         pin_oe    <= (state_r != RSMC_PIN_FLOAT);
         pc_active <= (state_r == RSMC_PIN_PRECHG);
      end
   end

endmodule : rsmc_precharge

// ---- sim/rsmc_board_model.sv ----
// Board model: hard reset and straps, plus pull-ups on three pins.
// Assumes the bench pulses go for one cycle with the wanted straps.
module rsmc_board_model (
   // Clock and control from the bench.
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic [3:0] mode,
   // Reset and straps: width, retry, quiesce ack, write-only.
   output logic            hard_reset_n,
   output logic [3:0]      straps,
   // Open bus pins.
   input  wire logic [2:0] pin_o,
   input  wire logic [2:0] pin_oe,
   output logic [2:0]      pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;

   // Hard reset starts asserted so nothing is captured early.
   initial begin
      hard_reset_n = 1'b0;
      straps = 4'h0;
      cnt_r = 4'h0;
   end

   // A released pin floats up to its inactive high level.
   assign pin_i = pin_o | ~pin_oe;

   always @(posedge clk_sys) begin
      if (go) begin
         cnt_r <= 4'h1;
         hard_reset_n <= 1'b0;
         straps <= mode;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= (cnt_r == 4'hA) ? 4'h0 : cnt_r + 4'h1;
         if (cnt_r == 4'h6) begin
            hard_reset_n <= 1'b1;
         end
         // straps move late, retry is driven low.
         if (cnt_r == 4'h9) begin
            straps <= {~mode[3], 1'b0, ~mode[1:0]};
         end
      end
   end
endmodule : rsmc_board_model

// ---- sim/rsmc_top_chk.sv ----
// Checker for strap capture and precharge of the address busy pin.
// Assumes it is bound to rsmc_top and sees only its ports.
module rsmc_top_chk #(
   parameter int BUS_CLKS = 4
) (
   // Clock, reset and straps.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic hard_reset_n,
   input wire logic bus_width_strap,
   input wire logic data_retry_in,
   input wire logic quiesce_ack_in,
   input wire logic write_only_strap,
   // One pin and the captured modes.
   input wire logic addr_bus_busy_req,
   input wire logic addr_bus_busy_n_o,
   input wire logic addr_bus_busy_n_oe,
   input wire logic cfg_valid_r,
   input wire logic bus_64bit_r,
   input wire logic data_retry_en_r,
   input wire logic ext_precharge_r,
   input wire logic pll_div_sel_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [3:0] hi_r;

   // Counts cycles driven high so the precharge length can be judged.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst)
         hi_r <= 4'h0;
      else
         hi_r <= (addr_bus_busy_n_o && addr_bus_busy_n_oe) ? hi_r + 4'h1 : 4'h0;
   end

   // Release seen by the first stage, then the capture latency.
   sequence s_rel; $rose(hard_reset_n) ##5 1'b1; endsequence
   sequence s_low; !addr_bus_busy_n_o && addr_bus_busy_n_oe; endsequence
   property p_valid; s_rel |-> cfg_valid_r; endproperty
   property p_width; s_rel |-> bus_64bit_r == $past(bus_width_strap, 5); endproperty
   property p_retry; s_rel |-> data_retry_en_r == $past(data_retry_in, 5); endproperty
   property p_pcmode; s_rel |-> ext_precharge_r != $past(quiesce_ack_in, 5); endproperty
   property p_pll; s_rel |-> pll_div_sel_r == $past(write_only_strap, 5); endproperty
   property p_hold;
      cfg_valid_r && $past(cfg_valid_r) |-> $stable({bus_64bit_r, data_retry_en_r, ext_precharge_r, pll_div_sel_r});
   endproperty
   property p_drive; $rose(addr_bus_busy_req) && cfg_valid_r |-> ##2 s_low; endproperty
   property p_pclen;
      $fell(addr_bus_busy_n_oe) |-> hi_r == (ext_precharge_r ? BUS_CLKS : BUS_CLKS / 2);
   endproperty

   a_valid: assert property (p_valid) else $error("modes not valid after release");
   a_width: assert property (p_width) else $error("bus width not captured");
   a_retry: assert property (p_retry) else $error("retry mode not captured");
   a_pcmode: assert property (p_pcmode) else $error("precharge mode not captured");
   a_pll: assert property (p_pll) else $error("divider select not captured");
   a_hold: assert property (p_hold) else $error("captured mode moved");
   a_drive: assert property (p_drive) else $error("pin not driven low");
   a_pclen: assert property (p_pclen) else $error("precharge length wrong");
endmodule : rsmc_top_chk

bind rsmc_top rsmc_top_chk #(.BUS_CLKS(BUS_CLKS)) u_chk (
   .clk_sys(clk_sys), .nrst(nrst), .hard_reset_n(hard_reset_n),
   .bus_width_strap(bus_width_strap), .data_retry_in(data_retry_in),
   .quiesce_ack_in(quiesce_ack_in), .write_only_strap(write_only_strap),
   .addr_bus_busy_req(addr_bus_busy_req), .addr_bus_busy_n_o(addr_bus_busy_n_o),
   .addr_bus_busy_n_oe(addr_bus_busy_n_oe), .cfg_valid_r(cfg_valid_r), .bus_64bit_r(bus_64bit_r),
   .data_retry_en_r(data_retry_en_r), .ext_precharge_r(ext_precharge_r), .pll_div_sel_r(pll_div_sel_r));

// ---- sim/rsmc_top_tb_top.sv ----
// Bench for strap capture and precharge of the busy and retry pins.
// Assumes rsmc_board_model stands for the board and its pull-ups.
module rsmc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BC = 4;
   logic       clk_sys = 1'b0;
   logic       nrst = 1'b0;
   logic       go = 1'b0;
   logic [3:0] mode = 4'h0;
   logic [2:0] req = 3'h0;
   logic       hard_reset_n;
   logic [3:0] straps;
   logic [2:0] pin_o, pin_oe, pin_i;
   logic [3:0] modes_v;
   logic       cfg_valid_r, err;
   logic       busy, seen;
   logic       retry_bad = 1'b0;
   int         idle_seen = 0;
   int         bad_count = 0;
   int         n_checks = 0;
   int         cyc = 0;
   // Straps {width, retry, quiesce, write-only} beside {64-bit, retry, extended, divider}.
   logic [7:0] rows [6] = '{8'hFD, 8'h02, 8'hA8, 8'h57, 8'h64, 8'h9B};

   always #20 clk_sys = ~clk_sys;

   rsmc_top #(.BUS_CLKS(BC), .CNT_W(4)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .hard_reset_n(hard_reset_n),
      .bus_width_strap(straps[3]), .data_retry_in(straps[2] | retry_bad),
      .quiesce_ack_in(straps[1]), .write_only_strap(straps[0]),
      .addr_bus_busy_req(req[0]), .data_bus_busy_req(req[1]), .addr_retry_req(req[2]),
      .addr_bus_busy_n_i(pin_i[0]), .addr_bus_busy_n_o(pin_o[0]), .addr_bus_busy_n_oe(pin_oe[0]),
      .data_bus_busy_n_i(pin_i[1]), .data_bus_busy_n_o(pin_o[1]), .data_bus_busy_n_oe(pin_oe[1]),
      .addr_retry_n_i(pin_i[2]), .addr_retry_n_o(pin_o[2]), .addr_retry_n_oe(pin_oe[2]),
      .cfg_valid_r(cfg_valid_r), .bus_64bit_r(modes_v[3]), .data_retry_en_r(modes_v[2]),
      .ext_precharge_r(modes_v[1]), .pll_div_sel_r(modes_v[0]),
      .retry_strap_err_r(err), .precharge_busy_r(busy), .bus_pins_seen_r(seen));

   rsmc_board_model board (.clk_sys(clk_sys), .go(go), .mode(mode), .hard_reset_n(hard_reset_n),
      .straps(straps), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic test_done;
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // One board reset cycle; capture lands a few edges after release.
   task automatic capture(input logic [3:0] m);
      @(posedge clk_sys);
      mode <= m;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (20) @(posedge clk_sys);
   endtask : capture

   // Assert one pin, release it, and count the high-driven cycles.
   task automatic pc(input int i, input int len);
      int n;
      int nb;
      int ns;
      n = 0;
      nb = 0;
      ns = 0;
      @(posedge clk_sys);
      req[i] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("pin low", 8'h00, pin_i[i]);
      @(posedge clk_sys);
      req[i] <= 1'b0;
      // The wire is low for four cycles; busy follows the precharge length.
      repeat (12) begin
         @(negedge clk_sys);
         n += int'(pin_o[i] & pin_oe[i]);
         nb += int'(busy);
         ns += int'(seen);
      end
      chk("precharge", 8'(len), 8'(n));
      chk("busy", 8'(len), 8'(nb));
      chk("seen", 8'h04, 8'(ns));
      chk("released", 8'h01, pin_i[i] & ~pin_oe[i]);
   endtask : pc

   // A hang is cut short far past the few hundred cycles needed.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         test_done();
      end
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      @(negedge clk_sys);
      chk("reset modes", 8'h08, {cfg_valid_r, modes_v});
      @(posedge clk_sys);
      req <= 3'h7;
      // Idle pins must not read as low while the filter fills after reset.
      repeat (6) begin
         @(negedge clk_sys);
         idle_seen += int'(seen);
      end
      chk("gated", 8'h00, pin_oe);
      chk("idle seen", 8'h00, 8'(idle_seen));
      @(posedge clk_sys);
      req <= 3'h0;
      foreach (rows[k]) begin
         capture(rows[k][7:4]);
         @(negedge clk_sys);
         chk("modes", {4'h1, rows[k][3:0]}, {cfg_valid_r, modes_v});
         chk("retry err", 8'h00, err);
      end
      for (int m = 0; m < 2; m++) begin
         capture(m ? 4'h8 : 4'hA);
         for (int i = 0; i < 3; i++)
            pc(i, m ? BC : BC / 2);
      end
      // A retry pulse with retry off sets the sticky error; a release clears it.
      @(posedge clk_sys);
      retry_bad <= 1'b1;
      repeat (3) @(posedge clk_sys);
      retry_bad <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("retry err set", 8'h01, err);
      capture(4'hA);
      @(negedge clk_sys);
      chk("retry err clear", 8'h00, err);
      test_done();
   end
endmodule : rsmc_top_tb_top
